//--- src/iodt_defs.vh
// Purpose: Constants for the integer-op decode and timing block.
// Assumes: APB register map, 40 MHz pclk.
// Notes:   Flag masks run overflow, direction, interrupt, trap, sign, zero, aux, parity, carry, bit 8 to 0.
// How it works
// RQ1: F8 clears carry, one clock.
// RQ2: FC clears direction flag, seven clocks.
// RQ3: FA clears interrupt enable, seven clocks.
// RQ4: 0F 06 clears task-switched bit, ten clocks, arithmetic flags untouched.
// RQ5: F5 inverts carry only, two clocks.
// RQ6: All compare_integers forms write six result flags in one clock.
// RQ7: 80..83 with reg field 111 is immediate compare.
// RQ8: A6/A7 compare_string writes result flags, five clocks.
// RQ9: 0F B0/B1 compare_and_swap writes result flags, eleven clocks.
// RQ10: 99 and 98 sign-extend in two clocks.
// RQ11: 27 decimal adjust after add, five flags, nine clocks.
// RQ12: 2F decimal adjust after subtract, five flags, nine clocks.
// RQ13: subtract_one forms take one clock, carry unchanged.
// RQ14: Unsigned divide 13-17, 13-25, 13-41 clocks by size; some flags undefined.
// RQ15: Signed divide 16-20, 16-28, 17-45 clocks by size.
// RQ16: C8 takes 10 plus three per nesting level.
// RQ17: F4 finishes in five clocks, then the halted state.
// RQ18: 0F A2 processor_identify takes twelve clocks.
// RQ19: Immediate size decoded as 8, 16 or full width.
// RQ20: Each flag is written, preserved or made undefined per mask.
// RQ21: w bit zero selects byte, one selects full width.
// RQ22: Counts assume hits; misses add stall cycles.
`ifndef IODT_DEFS_VH
`define IODT_DEFS_VH
`define IODT_A_INSN   8'h00
`define IODT_A_CTRL   8'h04
`define IODT_A_STAT   8'h08
`define IODT_A_FMASK  8'h0c
`define IODT_A_FLAGS  8'h10
`define IODT_A_LIVE   8'h14
`define IODT_FLAGS_RST 4'h0
`define IODT_F_CARRY  0
`define IODT_F_DIR    1
`define IODT_F_IF  2
`define IODT_F_TS  3
`define IODT_M_RES    9'h11f
`define IODT_M_SUB1   9'h11e
`define IODT_M_ADJ    9'h01f
`define IODT_M_DIVW   9'h118
`define IODT_M_DIVU   9'h006
`define IODT_T_CLRC   10'd1
`define IODT_T_CLRD   10'd7
`define IODT_T_MASKI  10'd7
`define IODT_T_CLRTS  10'd10
`define IODT_T_CPLC   10'd2
`define IODT_T_ICMP   10'd1
`define IODT_T_SCMP   10'd5
`define IODT_T_CAS    10'd11
`define IODT_T_IDENT  10'd12
`define IODT_T_SEXT   10'd2
`define IODT_T_ADJ    10'd9
`define IODT_T_SUB1   10'd1
`define IODT_T_HALT   10'd5
`define IODT_T_ENTER  10'd10
`define IODT_T_UDIV   10'd13
`define IODT_T_SDIV   10'd16
`define IODT_T_SDIV32 10'd17
`define IODT_SPAN_B   10'd4
`define IODT_SPAN_W   10'd12
`define IODT_SPAN_UD  10'd28
`define IODT_T_UNK    10'd1
`define IODT_IMM_NONE 3'd0
`define IODT_IMM_8    3'd1
`define IODT_IMM_16   3'd2
`define IODT_IMM_FULL 3'd3
`define IODT_IMM_16_8 3'd4
`endif

//--- src/iodt_core.v
// Purpose: Decodes one instruction and runs its core-clock latency and flag effects.
// Assumes: Single pclk domain; APB master keeps the request stable until pready.
// Notes:   Opcode bytes are written over APB, then a start bit launches execution.
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "iodt_defs.vh"
module iodt_core (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         busy,
  output reg         exec_done,
  output reg         halted,
  output reg         carry_flag,
  output reg         direction_flag
);
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_EXEC = 2'b10;

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  reg [31:0] insn_r;
  reg [15:0] ctrl_r;
  reg [3:0]  flags_r;
  reg [1:0]  state_r;
  reg [9:0]  cnt_r;
  reg [9:0]  lat_r;
  reg [8:0]  wmask_r;
  reg [8:0]  umask_r;
  reg [8:0]  zmask_r;
  reg [4:0]  cls_r;
  reg [2:0]  imm_r;
  reg        valid_r;

  wire [7:0] b0    = insn_r[7:0];
  wire [7:0] b1    = insn_r[15:8];
  wire [2:0] regf  = insn_r[21:19];
  wire [7:0] level = insn_r[31:24];
  wire acc     = psel && penable && pready;
  wire wr      = acc && pwrite;
  wire start   = wr && (paddr == `IODT_A_CTRL) && pwdata[0] && state_r[0];

  // The start write carries its own options, so decode sees them on that edge.
  wire [15:0] ctrl_v = (wr && paddr == `IODT_A_CTRL && state_r[0]) ? pwdata[15:0] : ctrl_r;
  wire [4:0]  qext   = ctrl_v[5:1];
  wire        op32   = ctrl_v[7];
  wire        miss   = ctrl_v[6];
  wire [7:0]  stall  = ctrl_v[15:8];

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  reg [9:0] lat_nxt;
  reg [9:0] span;
  reg [9:0] qadd;
  reg [8:0] wm_nxt;
  reg [8:0] um_nxt;
  reg [8:0] zm_nxt;
  reg [4:0] cls_nxt;
  reg [2:0] imm_nxt;
  reg       val_nxt;
  reg       wide;

  always @* begin
    lat_nxt = `IODT_T_UNK;
    wm_nxt  = 9'h000;
    um_nxt  = 9'h000;
    zm_nxt  = 9'h000;
    cls_nxt = 5'h00;
    imm_nxt = `IODT_IMM_NONE;
    val_nxt = 1'b1;
    wide    = b0[0]; // RQ21
    span    = wide ? (op32 ? `IODT_SPAN_UD : `IODT_SPAN_W) : `IODT_SPAN_B;
    qadd    = ({5'h00, qext} > span) ? span : {5'h00, qext};
    if (b0 == 8'hf8) begin
      cls_nxt = 5'h01; lat_nxt = `IODT_T_CLRC; zm_nxt = 9'h001; // RQ1
    end else if (b0 == 8'hfc) begin
      cls_nxt = 5'h02; lat_nxt = `IODT_T_CLRD; zm_nxt = 9'h080; // RQ2
    end else if (b0 == 8'hfa) begin
      cls_nxt = 5'h03; lat_nxt = `IODT_T_MASKI; zm_nxt = 9'h040; // RQ3
    end else if (b0 == 8'h0f && b1 == 8'h06) begin
      cls_nxt = 5'h04; lat_nxt = `IODT_T_CLRTS; // RQ4
    end else if (b0 == 8'hf5) begin
      cls_nxt = 5'h05; lat_nxt = `IODT_T_CPLC; wm_nxt = 9'h001; // RQ5
    end else if (b0[7:2] == 6'b001110 || b0[7:1] == 7'b0011110) begin
      cls_nxt = 5'h06; lat_nxt = `IODT_T_ICMP; wm_nxt = `IODT_M_RES; // RQ6
      if (b0[2])
        imm_nxt = wide ? `IODT_IMM_FULL : `IODT_IMM_8; // RQ19
    end else if (b0[7:2] == 6'b100000 && regf == 3'b111) begin
      cls_nxt = 5'h07; lat_nxt = `IODT_T_ICMP; wm_nxt = `IODT_M_RES; // RQ7
      imm_nxt = (b0[1:0] == 2'b01) ? `IODT_IMM_FULL : `IODT_IMM_8; // RQ19
    end else if (b0[7:1] == 7'b1010011) begin
      cls_nxt = 5'h08; lat_nxt = `IODT_T_SCMP; wm_nxt = `IODT_M_RES; // RQ8
    end else if (b0 == 8'h0f && b1[7:1] == 7'b1011000) begin
      cls_nxt = 5'h09; lat_nxt = `IODT_T_CAS; wm_nxt = `IODT_M_RES; // RQ9
    end else if (b0 == 8'h0f && b1 == 8'ha2) begin
      cls_nxt = 5'h0a; lat_nxt = `IODT_T_IDENT; // RQ18
    end else if (b0[7:1] == 7'b1001100) begin
      cls_nxt = 5'h0b; lat_nxt = `IODT_T_SEXT; // RQ10
    end else if (b0 == 8'h27 || b0 == 8'h2f) begin
      cls_nxt = b0[3] ? 5'h0d : 5'h0c; lat_nxt = `IODT_T_ADJ; wm_nxt = `IODT_M_ADJ; // RQ11 RQ12
    end else if (b0[7:3] == 5'b01001 ||
                 (b0[7:1] == 7'b1111111 && regf == 3'b001)) begin
      cls_nxt = 5'h0e; lat_nxt = `IODT_T_SUB1; wm_nxt = `IODT_M_SUB1; // RQ13
    end else if (b0[7:1] == 7'b1111011 && regf == 3'b110) begin
      cls_nxt = 5'h0f; lat_nxt = `IODT_T_UDIV + qadd; // RQ14
      wm_nxt  = `IODT_M_DIVW; um_nxt = `IODT_M_DIVU; // RQ20
    end else if (b0[7:1] == 7'b1111011 && regf == 3'b111) begin
      cls_nxt = 5'h10; wm_nxt = `IODT_M_DIVW; um_nxt = `IODT_M_DIVU;
      lat_nxt = ((wide && op32) ? `IODT_T_SDIV32 : `IODT_T_SDIV) + qadd; // RQ15
    end else if (b0 == 8'hc8) begin
      cls_nxt = 5'h11; imm_nxt = `IODT_IMM_16_8; // RQ19
      lat_nxt = `IODT_T_ENTER + {level, 1'b0} + {2'b00, level}; // RQ16
    end else if (b0 == 8'hf4) begin
      cls_nxt = 5'h12; lat_nxt = `IODT_T_HALT; // RQ17
    end else begin
      val_nxt = 1'b0;
    end
    if (miss)
      lat_nxt = lat_nxt + {2'b00, stall}; // RQ22
  end

  // ----------------------------------------
  // Execution sequencer
  // ----------------------------------------
  // Flag effects land on the last cycle, so a read mid-instruction
  // still shows the state from before it.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r   <= ST_IDLE;
      cnt_r     <= 10'd0;
      lat_r     <= 10'd0;
      wmask_r   <= 9'h000;
      umask_r   <= 9'h000;
      zmask_r   <= 9'h000;
      cls_r     <= 5'h00;
      imm_r     <= `IODT_IMM_NONE;
      valid_r   <= 1'b0;
      flags_r   <= `IODT_FLAGS_RST;
      busy      <= 1'b0;
      exec_done <= 1'b0;
      halted    <= 1'b0;
    end else if (ce) begin
      exec_done <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (wr && paddr == `IODT_A_FLAGS)
            flags_r <= pwdata[3:0];
          if (start) begin
            state_r <= ST_EXEC;
            busy    <= 1'b1;
            halted  <= 1'b0;
            cnt_r   <= lat_nxt;
            lat_r   <= lat_nxt;
            wmask_r <= wm_nxt;
            umask_r <= um_nxt;
            zmask_r <= zm_nxt;
            cls_r   <= cls_nxt;
            imm_r   <= imm_nxt;
            valid_r <= val_nxt;
          end
        end
        ST_EXEC: begin
          cnt_r <= cnt_r - 10'd1;
          if (cnt_r == 10'd1) begin
            state_r   <= ST_IDLE;
            busy      <= 1'b0;
            exec_done <= 1'b1;
            case (cls_r)
              5'h01: flags_r[`IODT_F_CARRY] <= 1'b0; // RQ1
              5'h02: flags_r[`IODT_F_DIR] <= 1'b0; // RQ2
              5'h03: flags_r[`IODT_F_IF] <= 1'b0; // RQ3
              5'h04: flags_r[`IODT_F_TS] <= 1'b0; // RQ4
              5'h05: flags_r[`IODT_F_CARRY] <= ~flags_r[`IODT_F_CARRY]; // RQ5
              5'h12: halted <= 1'b1; // RQ17
              default: flags_r <= flags_r;
            endcase
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // No wait state: pready is already high in the first access cycle, so outputs stay registered.
  reg [31:0] rd_nxt;
  reg        err_nxt;

  always @* begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = 1'b0;
    case (paddr)
      `IODT_A_INSN:  rd_nxt = insn_r;
      `IODT_A_CTRL:  rd_nxt = {16'h0000, ctrl_r};
      `IODT_A_STAT:  rd_nxt = {6'h00, lat_r, 3'h0, imm_r, 2'b00, cls_r, halted, valid_r, busy};
      `IODT_A_FMASK: rd_nxt = {5'h00, umask_r, zmask_r, wmask_r};
      `IODT_A_FLAGS: rd_nxt = {28'h0000000, flags_r};
      `IODT_A_LIVE:  rd_nxt = {6'h00, lat_nxt, 5'h00, imm_nxt, 2'b00, cls_nxt, val_nxt};
      default:       err_nxt = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      insn_r         <= 32'h0000_0000;
      ctrl_r         <= 16'h0000;
      prdata         <= 32'h0000_0000;
      pready         <= 1'b0;
      pslverr        <= 1'b0;
      carry_flag     <= 1'b0;
      direction_flag <= 1'b0;
    end else if (ce) begin
      pready         <= psel && !penable && !pready;
      pslverr        <= psel && !penable && !pready && err_nxt;
      carry_flag     <= flags_r[`IODT_F_CARRY];
      direction_flag <= flags_r[`IODT_F_DIR];
      if (psel && !penable && !pwrite)
        prdata <= rd_nxt;
      if (wr && paddr == `IODT_A_INSN && state_r[0])
        insn_r <= pwdata;
      if (wr && paddr == `IODT_A_CTRL && state_r[0])
        ctrl_r <= {pwdata[15:1], 1'b0};
    end
  end
endmodule

//--- verif/iodt_core_sva.sv
// Purpose: Port-level timing checks for the decode core.
// Assumes: One pclk domain; ce held high while checked.
// Notes:   Bound to every core instance at the foot of this file.
`timescale 1ns/1ps
`include "iodt_defs.vh"
module iodt_core_sva (
  input wire        pclk,
  input wire        presetn,
  input wire        ce,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        busy,
  input wire        exec_done,
  input wire        halted,
  input wire        carry_flag,
  input wire        direction_flag
);
  // A start is only taken on the access edge of a CTRL write.
  wire go = psel && penable && pready && pwrite && paddr == `IODT_A_CTRL && pwdata[0];
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  start_busy_a: assert property (ce && go && !busy |=> busy)
    else $error("Start not taken.");
  busy_cause_a: assert property ($rose(busy) |-> $past(go))
    else $error("Busy without a start.");
  done_busy_a: assert property (exec_done |-> !busy && $past(busy))
    else $error("Done outside execution.");
  done_end_a: assert property (ce && exec_done |=> !busy && !exec_done)
    else $error("Execution did not end after done.");
  lat_bound_a: assert property ($rose(busy) |-> ##[0:300] exec_done)
    else $error("Execution overran.");
  halt_done_a: assert property ($rose(halted) |-> exec_done || $past(exec_done))
    else $error("Halted without completion.");
  carry_idle_a: assert property ($changed(carry_flag) |-> !busy)
    else $error("Carry moved mid execution.");
  dir_idle_a: assert property ($changed(direction_flag) |-> !busy)
    else $error("Direction moved mid execution.");
endmodule
bind iodt_core iodt_core_sva u_sva (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .busy(busy), .exec_done(exec_done), .halted(halted), .carry_flag(carry_flag),
  .direction_flag(direction_flag));

//--- verif/integer_op_decode_timing_tb.sv
// Purpose: Self-checking bench for the decode and timing core.
// Assumes: ce held high; flags preset to all ones before each case.
// Notes:   Latency counts edges from the CTRL access edge to exec_done.
`timescale 1ns/1ps
`include "iodt_defs.vh"
module integer_op_decode_timing_tb;
  reg         pclk, presetn, ce, psel, penable, pwrite, err;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire        pready, pslverr, busy, exec_done, halted, carry_flag, direction_flag;
  integer     fails, n_checks, n, i;

  iodt_core dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .busy(busy), .exec_done(exec_done), .halted(halted), .carry_flag(carry_flag),
    .direction_flag(direction_flag));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task check(input [8*10:1] what, input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("[FAIL] %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && i < 20) begin
        @(posedge pclk);
        i = i + 1;
      end
      if (i == 20) begin
        fails = fails + 1;
        wrap_up;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // Flags are preset to all ones so that every clear shows.
  task run(input [31:0] insn, input [31:0] ctrl, input [31:0] lat, input [3:0] fx, input [3:0] fm);
    begin
      apb(1'b1, `IODT_A_FLAGS, 32'hf);
      apb(1'b1, `IODT_A_INSN, insn);
      apb(1'b1, `IODT_A_CTRL, ctrl | 32'h1);
      for (n = 1; n < 400; n = n + 1) begin
        @(posedge pclk);
        #1;
        if (exec_done === 1'b1) break;
      end
      check("latency", n, lat);
      if (n == 400) wrap_up;
      apb(1'b0, `IODT_A_FLAGS, 32'h0);
      check("flags", {28'h0, rd[3:0] & fm}, {28'h0, fx & fm});
      if (fm[0]) check("carry", carry_flag, fx[0]);
      if (fm[1]) check("direction", direction_flag, fx[1]);
    end
  endtask

  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fails = 0;
    n_checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `IODT_A_FLAGS, 32'h0);
    check("flags_rst", rd, {28'h0, `IODT_FLAGS_RST});
    apb(1'b0, 8'h20, 32'h0);
    check("slverr", err, 1'b1);
    check("err_data", rd, 32'h0);
    run(32'hf8, 32'h0, 1, 4'he, 4'hf);
    run(32'hfc, 32'h0, 7, 4'hd, 4'hf);
    run(32'hfa, 32'h0, 7, 4'hb, 4'hf);
    run(32'h060f, 32'h0, 10, 4'h7, 4'hf);
    run(32'hf5, 32'h0, 2, 4'he, 4'hf);
    run(32'h00c0_0039, 32'h0, 1, 4'he, 4'he);
    run(32'h0000_0038, 32'h0, 1, 4'he, 4'he);
    run(32'h0000_003d, 32'h0, 1, 4'he, 4'he);
    apb(1'b0, `IODT_A_LIVE, 32'h0);
    check("imm_full", rd[10:8], `IODT_IMM_FULL);
    run(32'h00f8_0080, 32'h0, 1, 4'he, 4'he);
    run(32'h00f8_0083, 32'h0, 1, 4'he, 4'he);
    run(32'ha7, 32'h0, 5, 4'he, 4'he);
    run(32'hb10f, 32'h0, 11, 4'he, 4'he);
    run(32'hb00f, 32'h0, 11, 4'he, 4'he);
    run(32'ha20f, 32'h0, 12, 4'hf, 4'hf);
    run(32'h99, 32'h0, 2, 4'hf, 4'hf);
    run(32'h98, 32'h0, 2, 4'hf, 4'hf);
    run(32'h27, 32'h0, 9, 4'he, 4'he);
    run(32'h2f, 32'h0, 9, 4'he, 4'he);
    run(32'h48, 32'h0, 1, 4'hf, 4'hf);
    run(32'h00c8_00fe, 32'h0, 1, 4'hf, 4'hf);
    run(32'h00f0_00f6, 32'h0, 13, 4'hf, 4'hf);
    run(32'h00f0_00f6, 32'h3e, 17, 4'hf, 4'hf);
    run(32'h00f0_00f7, 32'h3e, 25, 4'hf, 4'hf);
    run(32'h00f0_00f7, 32'hbe, 41, 4'hf, 4'hf);
    run(32'h00f8_00f6, 32'h0, 16, 4'hf, 4'hf);
    run(32'h00f8_00f6, 32'h3e, 20, 4'hf, 4'hf);
    run(32'h00f8_00f7, 32'h3e, 28, 4'hf, 4'hf);
    run(32'h00f8_00f7, 32'h80, 17, 4'hf, 4'hf);
    run(32'h00f8_00f7, 32'hbe, 45, 4'hf, 4'hf);
    run(32'h0000_00c8, 32'h0, 10, 4'hf, 4'hf);
    run(32'h0100_00c8, 32'h0, 13, 4'hf, 4'hf);
    run(32'h0300_00c8, 32'h0, 19, 4'hf, 4'hf);
    apb(1'b0, `IODT_A_LIVE, 32'h0);
    check("imm_enter", rd[10:8], `IODT_IMM_16_8);
    run(32'hf4, 32'h0, 5, 4'hf, 4'hf);
    check("halted", halted, 1'b1);
    run(32'hf8, 32'h0340, 4, 4'he, 4'hf);
    check("resumed", halted, 1'b0);
    wrap_up;
  end
endmodule
